// ===== sec_pkg.sv
package sec_pkg;
  // Register word, address and revision field widths
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned REV_W  = 4;

  // Register offsets
  localparam logic [7:0] SOFT_RESET_WORD_OFS = 8'h00;
  localparam logic [7:0] SILICON_REV_OFS     = 8'h01;
  localparam logic [7:0] PWR_MGMT1_OFS       = 8'h02;
  localparam logic [7:0] PWR_MGMT2_OFS       = 8'h03;
  localparam logic [7:0] ADD_CTL_OFS         = 8'h07;

  // Values after reset
  localparam logic [15:0] PWR_MGMT1_RST = 16'h0000;
  localparam logic [15:0] PWR_MGMT2_RST = 16'h0310;
  localparam logic [15:0] ADD_CTL_RST   = 16'h800D;
  localparam logic [15:0] RDATA_RST     = 16'h0000;

  // Identity values, arbitrary
  localparam logic [15:0] FAMILY_ID_DEF = 16'hA5C3;
  localparam logic [3:0]  SILICON_REV_DEF = 4'h1;

  // Field positions in the revision register
  localparam int unsigned REV_LSB = 0;
  localparam int unsigned REV_MSB = 3;

  // Power-on reset synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;
endpackage : sec_pkg

// ===== sec_wr_if.sv
`timescale 1ns/1ps
interface sec_wr_if;
  logic        wr_en;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        clear;

  modport master (output wr_en, output addr, output wdata, output clear);
  modport slave  (input wr_en, input addr, input wdata, input clear);
endinterface : sec_wr_if

// ===== sec_ctl_reg.sv
`timescale 1ns/1ps
module sec_ctl_reg #(
  parameter logic [7:0]  OFFSET  = 8'h00,
  parameter logic [15:0] DEFAULT = 16'h0000
) (
  // Clock and reset
  input  wire logic    clk_in,
  input  wire logic    resetn_in,
  // Write carrier
  sec_wr_if.slave      bus,
  // Stored value
  output logic [15:0]  value_out
);

  // Decode of a write to this register
  wire hit = bus.wr_en && (bus.addr == OFFSET);

  logic [15:0] value_nxt;
  assign value_nxt = bus.clear ? DEFAULT : (hit ? bus.wdata : value_out);

  // Storage, cleared back to its default by a soft reset
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      value_out <= DEFAULT;
    end else begin
      value_out <= value_nxt;
    end
  end

  clear_default_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    bus.clear |=> value_out == $past(DEFAULT))
    else $error("control register not at default after clear");

endmodule : sec_ctl_reg

// ===== sec_reset_id.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Any write to word zero restores defaults
// - Word zero read value never changes
// - Word zero reads fixed family identifier
// - Word one low nibble is revision
// - Writes ignored while power-on reset asserted
module sec_reset_id #(
  parameter logic [15:0] FAMILY_ID   = sec_pkg::FAMILY_ID_DEF,
  parameter logic [3:0]  SILICON_REV = sec_pkg::SILICON_REV_DEF
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // Internal power-on reset, active low, asynchronous
  input  wire logic        por_n_in,
  // Register write port from the control interface
  input  wire logic        wr_en_in,
  input  wire logic [7:0]  wr_addr_in,
  input  wire logic [15:0] wr_data_in,
  // Register read port from the control interface
  input  wire logic        rd_en_in,
  input  wire logic [7:0]  rd_addr_in,
  output logic [15:0]      rd_data_out,
  output logic             rd_valid_out,
  // Status and control to the rest of the device
  output logic             soft_reset_out,
  output logic             por_ready_out,
  output logic [15:0]      pwr_mgmt1_out,
  output logic [15:0]      pwr_mgmt2_out,
  output logic [15:0]      add_ctl_out
);

  // Elaboration checks on the shared constants
  if (sec_pkg::REV_W > sec_pkg::DATA_W) begin : g_bad_rev_w
    $error("revision field wider than a register word");
  end
  if (sec_pkg::REV_MSB - sec_pkg::REV_LSB + 1 != sec_pkg::REV_W) begin : g_bad_rev_pos
    $error("revision field position does not match its width");
  end
  if (sec_pkg::SYNC_STAGES != 2) begin : g_bad_sync
    $error("power-on reset synchroniser is built with two stages only");
  end

  // Power-on reset synchroniser
  logic por_meta_r;
  logic por_ok_r;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      por_meta_r <= 1'b0;
      por_ok_r   <= 1'b0;
    end else begin
      por_meta_r <= por_n_in;
      por_ok_r   <= por_meta_r;
    end
  end

  // Write qualification and soft reset decode
  wire wr_accept = wr_en_in && por_ok_r;
  wire soft_hit  = wr_accept && (wr_addr_in == sec_pkg::SOFT_RESET_WORD_OFS);

  sec_wr_if wbus ();
  assign wbus.wr_en = wr_accept;
  assign wbus.addr  = wr_addr_in;
  assign wbus.wdata = wr_data_in;
  assign wbus.clear = soft_hit || !por_ok_r;

  // Control registers returned to default by a soft reset
  sec_ctl_reg #(.OFFSET(sec_pkg::PWR_MGMT1_OFS), .DEFAULT(sec_pkg::PWR_MGMT1_RST)) u_pm1 (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .bus       (wbus),
    .value_out (pwr_mgmt1_out)
  );
  sec_ctl_reg #(.OFFSET(sec_pkg::PWR_MGMT2_OFS), .DEFAULT(sec_pkg::PWR_MGMT2_RST)) u_pm2 (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .bus       (wbus),
    .value_out (pwr_mgmt2_out)
  );
  sec_ctl_reg #(.OFFSET(sec_pkg::ADD_CTL_OFS), .DEFAULT(sec_pkg::ADD_CTL_RST)) u_add (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .bus       (wbus),
    .value_out (add_ctl_out)
  );

  // Read data selection; identity words are constants
  logic [15:0] rev_word;
  logic [15:0] rd_sel;
  assign rev_word = {{(16 - sec_pkg::REV_W){1'b0}}, SILICON_REV};
  assign rd_sel =
    (rd_addr_in == sec_pkg::SOFT_RESET_WORD_OFS) ? FAMILY_ID :
    (rd_addr_in == sec_pkg::SILICON_REV_OFS)     ? rev_word :
    (rd_addr_in == sec_pkg::PWR_MGMT1_OFS)       ? pwr_mgmt1_out :
    (rd_addr_in == sec_pkg::PWR_MGMT2_OFS)       ? pwr_mgmt2_out :
    (rd_addr_in == sec_pkg::ADD_CTL_OFS)         ? add_ctl_out :
                                                   sec_pkg::RDATA_RST;

  logic [15:0] rd_data_nxt;
  assign rd_data_nxt = rd_en_in ? rd_sel : rd_data_out;

  // Read answer one cycle after the request
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_out  <= sec_pkg::RDATA_RST;
      rd_valid_out <= 1'b0;
    end else begin
      rd_data_out  <= rd_data_nxt;
      rd_valid_out <= rd_en_in;
    end
  end

  // Status pulse and ready level
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      soft_reset_out <= 1'b0;
      por_ready_out  <= 1'b0;
    end else begin
      soft_reset_out <= soft_hit;
      por_ready_out  <= por_ok_r;
    end
  end

  // Checks
  soft_pulse_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_en_in && por_ok_r && wr_addr_in == 8'h00) |=> soft_reset_out)
    else $error("soft reset pulse missing after write to word zero");

  soft_defaults_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    soft_reset_out |-> (pwr_mgmt1_out == 16'h0000 && pwr_mgmt2_out == 16'h0310
                        && add_ctl_out == 16'h800D))
    else $error("registers not at defaults after soft reset");

  family_read_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (rd_en_in && rd_addr_in == 8'h00) |=> (rd_valid_out && rd_data_out == FAMILY_ID))
    else $error("word zero did not read the family identifier");

  id_after_write_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_en_in && wr_addr_in == 8'h00 && wr_data_in != FAMILY_ID) ##1
    (rd_en_in && rd_addr_in == 8'h00) |=> rd_data_out == FAMILY_ID)
    else $error("write changed word zero read value");

  rev_read_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (rd_en_in && rd_addr_in == 8'h01) |=> (rd_data_out[15:4] == 12'h000
                                          && rd_data_out[3:0] == SILICON_REV))
    else $error("revision word read wrong");

  por_ignore_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!por_ok_r && wr_en_in && wr_addr_in == 8'h03) |=> pwr_mgmt2_out == 16'h0310)
    else $error("write taken while power-on reset asserted");

  por_soft_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!por_ok_r && wr_en_in) |=> !soft_reset_out)
    else $error("soft reset taken while power-on reset asserted");

  write_store_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (por_ok_r && wr_en_in && wr_addr_in == 8'h07) |=> add_ctl_out == $past(wr_data_in))
    else $error("accepted write not stored");

  pm1_store_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (por_ok_r && wr_en_in && wr_addr_in == sec_pkg::PWR_MGMT1_OFS)
    |=> pwr_mgmt1_out == $past(wr_data_in))
    else $error("accepted write to first power word not stored");

  pm2_store_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (por_ok_r && wr_en_in && wr_addr_in == sec_pkg::PWR_MGMT2_OFS)
    |=> pwr_mgmt2_out == $past(wr_data_in))
    else $error("accepted write to second power word not stored");

  por_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !por_ok_r |=> (pwr_mgmt1_out == sec_pkg::PWR_MGMT1_RST && pwr_mgmt2_out == sec_pkg::PWR_MGMT2_RST
                   && add_ctl_out == sec_pkg::ADD_CTL_RST))
    else $error("control words left default while power-on reset asserted");

  por_ready_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    1'b1 |=> por_ready_out == $past(por_ok_r))
    else $error("ready level does not follow released power-on reset");

  pm1_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (por_ok_r && !(wr_en_in && (wr_addr_in == sec_pkg::PWR_MGMT1_OFS
                                || wr_addr_in == sec_pkg::SOFT_RESET_WORD_OFS)))
    |=> $stable(pwr_mgmt1_out))
    else $error("first power word changed without a write");

  pm2_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (por_ok_r && !(wr_en_in && (wr_addr_in == sec_pkg::PWR_MGMT2_OFS
                                || wr_addr_in == sec_pkg::SOFT_RESET_WORD_OFS)))
    |=> $stable(pwr_mgmt2_out))
    else $error("second power word changed without a write");

  add_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (por_ok_r && !(wr_en_in && (wr_addr_in == sec_pkg::ADD_CTL_OFS
                                || wr_addr_in == sec_pkg::SOFT_RESET_WORD_OFS)))
    |=> $stable(add_ctl_out))
    else $error("additional control word changed without a write");

  soft_only_zero_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !(wr_en_in && wr_addr_in == sec_pkg::SOFT_RESET_WORD_OFS) |=> !soft_reset_out)
    else $error("soft reset pulse without a write to word zero");

  rd_answer_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    rd_en_in |=> rd_valid_out)
    else $error("read answer missing one cycle after request");

  rd_quiet_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !rd_en_in |=> (!rd_valid_out && $stable(rd_data_out)))
    else $error("read answer changed without a request");

  rd_old_value_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (rd_en_in && rd_addr_in == sec_pkg::PWR_MGMT2_OFS) |=> rd_data_out == $past(pwr_mgmt2_out))
    else $error("read of second power word returned wrong value");

  rev_write_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_en_in && wr_addr_in == sec_pkg::SILICON_REV_OFS) ##1
    (rd_en_in && rd_addr_in == sec_pkg::SILICON_REV_OFS) |=> rd_data_out[3:0] == SILICON_REV)
    else $error("write changed revision field");

  unmapped_read_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (rd_en_in && rd_addr_in != sec_pkg::SOFT_RESET_WORD_OFS && rd_addr_in != sec_pkg::SILICON_REV_OFS
     && rd_addr_in != sec_pkg::PWR_MGMT1_OFS && rd_addr_in != sec_pkg::PWR_MGMT2_OFS
     && rd_addr_in != sec_pkg::ADD_CTL_OFS) |=> rd_data_out == sec_pkg::RDATA_RST)
    else $error("unmapped word did not read zero");

endmodule : sec_reset_id

// ===== sec_host_model.sv
`timescale 1ns/1ps
module sec_host_model (
  // Clock
  input  wire logic  clk_in,
  // Requests to the device
  output logic        wr_en_out,
  output logic [7:0]  wr_addr_out,
  output logic [15:0] wr_data_out,
  output logic        rd_en_out,
  output logic [7:0]  rd_addr_out
);
  // Idle request lines
  initial begin
    wr_en_out = 1'b0;
    wr_addr_out = 8'h5A;
    wr_data_out = 16'hA5A5;
    rd_en_out = 1'b0;
    rd_addr_out = 8'hA5;
  end

  // One write, held to its sampling edge, lines inverted once released
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    #1;
    wr_en_out = 1'b1;
    wr_addr_out = a;
    wr_data_out = d;
    @(posedge clk_in);
    #1;
    wr_en_out = 1'b0;
    wr_addr_out = ~a;
    wr_data_out = ~d;
  endtask : wr

  // One read request, answer sampled by the caller
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    #1;
    rd_en_out = 1'b1;
    rd_addr_out = a;
    @(posedge clk_in);
    #1;
    rd_en_out = 1'b0;
    rd_addr_out = ~a;
  endtask : rd
endmodule : sec_host_model

// ===== test_soft_reset_id_power_sequencing.sv
`timescale 1ns/1ps
module test_soft_reset_id_power_sequencing;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        por_n_in = 1'b0;
  logic        wr_en, rd_en, rd_valid, srst, por_rdy;
  logic [7:0]  wa, ra;
  logic [15:0] wd, rdat, pm1, pm2, addc;
  logic [15:0] st = 16'h0036;
  logic [15:0] exp_w [3];
  logic [7:0]  adr_t [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h05};
  int          err_count = 0;
  int          n_compared = 0;
  // Settling waits in cycles, scaled down from milliseconds
  localparam int DLY_REG = 60;
  localparam int DLY_REF = 10;
  localparam int DLY_DIS = 100;

  // Clock
  always #2.5 clk_in = ~clk_in;

  sec_host_model host_u (.clk_in(clk_in), .wr_en_out(wr_en), .wr_addr_out(wa), .wr_data_out(wd),
                         .rd_en_out(rd_en), .rd_addr_out(ra));
  sec_reset_id dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .por_n_in(por_n_in), .wr_en_in(wr_en),
                      .wr_addr_in(wa), .wr_data_in(wd), .rd_en_in(rd_en), .rd_addr_in(ra),
                      .rd_data_out(rdat), .rd_valid_out(rd_valid), .soft_reset_out(srst),
                      .por_ready_out(por_rdy), .pwr_mgmt1_out(pm1), .pwr_mgmt2_out(pm2), .add_ctl_out(addc));

  // Compare and count
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  function automatic logic [15:0] xs();
    st = st ^ (st << 7);
    st = st ^ (st >> 9);
    st = st ^ (st << 8);
    return st;
  endfunction : xs

  // Expected read value of each word
  function automatic logic [15:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h00: return sec_pkg::FAMILY_ID_DEF;
      8'h01: return {12'h000, sec_pkg::SILICON_REV_DEF};
      8'h02: return exp_w[0];
      8'h03: return exp_w[1];
      8'h07: return exp_w[2];
      default: return 16'h0000;
    endcase
  endfunction : exp_rd

  task automatic set_defaults();
    exp_w = '{sec_pkg::PWR_MGMT1_RST, sec_pkg::PWR_MGMT2_RST, sec_pkg::ADD_CTL_RST};
  endtask : set_defaults

  task automatic rd_chk(input logic [7:0] a);
    host_u.rd(a);
    check("rd_valid", {15'h0000, rd_valid}, 16'h0001);
    check("rd_data", rdat, exp_rd(a));
  endtask : rd_chk

  // Write, track the model, compare the word outputs
  task automatic wr_chk(input logic [7:0] a, input logic [15:0] d);
    host_u.wr(a, d);
    if (a == 8'h00) set_defaults();
    if (a == 8'h02) exp_w[0] = d;
    if (a == 8'h03) exp_w[1] = d;
    if (a == 8'h07) exp_w[2] = d;
    check("soft_reset", {15'h0000, srst}, {15'h0000, a == 8'h00});
    check("pwr_mgmt1", pm1, exp_w[0]);
    check("pwr_mgmt2", pm2, exp_w[1]);
    check("add_ctl", addc, exp_w[2]);
  endtask : wr_chk

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // Recommended power-up then power-down, words outside this block ignored
  task automatic power_seq();
    wr_chk(8'h00, 16'h0000);
    wr_chk(8'h2A, 16'h34D0);
    wr_chk(8'h07, 16'h89AD);
    wr_chk(8'h35, 16'hC020);
    repeat (DLY_REG) @(posedge clk_in);
    wr_chk(8'h02, 16'h000F);
    wr_chk(8'h2A, 16'h3400);
    wr_chk(8'h03, 16'h53D5);
    wr_chk(8'h03, 16'h5FD5);
    wr_chk(8'h07, 16'h89BD);
    repeat (DLY_REF) @(posedge clk_in);
    wr_chk(8'h35, 16'h8000);
    wr_chk(8'h07, 16'h80BD);
    wr_chk(8'h02, 16'h000D);
    wr_chk(8'h03, 16'h5CD5);
    wr_chk(8'h2F, 16'h0040);
    wr_chk(8'h17, 16'h0100);
    wr_chk(8'h35, 16'hC020);
    wr_chk(8'h02, 16'h000F);
    wr_chk(8'h07, 16'h88BD);
    wr_chk(8'h07, 16'h88AD);
    repeat (DLY_DIS) @(posedge clk_in);
    wr_chk(8'h2A, 16'h34D0);
    repeat (DLY_REF) @(posedge clk_in);
    wr_chk(8'h2A, 16'h35D0);
    wr_chk(8'h03, 16'h5FD5);
    wr_chk(8'h03, 16'h53D5);
    wr_chk(8'h03, 16'h5315);
    wr_chk(8'h00, 16'h0000);
  endtask : power_seq

  // Main sequence
  initial begin
    set_defaults();
    repeat (6) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    host_u.wr(8'h03, 16'hFFFF);
    rd_chk(8'h03);
    por_n_in = 1'b1;
    for (int k = 0; k < 8 && por_rdy !== 1'b1; k++) @(posedge clk_in);
    #1;
    check("por_ready", {15'h0000, por_rdy}, 16'h0001);
    if (por_rdy !== 1'b1) complete_run();
    wr_chk(8'h03, 16'hFFFF);
    wr_chk(8'h00, 16'h0000);
    rd_chk(8'h03);
    power_seq();
    rd_chk(8'h07);
    for (int i = 0; i < 60; i++) begin
      wr_chk(adr_t[xs() % 6], xs());
      rd_chk(adr_t[xs() % 6]);
    end
    complete_run();
  end
endmodule : test_soft_reset_id_power_sequencing
